// ### src/fim_top.sv
// framer interrupt generation and register map decode
`timescale 1ns/1ps
`default_nettype none
module fim_top
    import fim_pkg::*;
#(
    // identification bytes; the values are arbitrary
    parameter logic [7:0] IDENT_0 = 8'h5a,
    parameter logic [7:0] IDENT_1 = 8'h01,
    parameter logic [7:0] IDENT_2 = 8'h10
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host register port
    input wire fim_bus_req_t bus_req,
    output var fim_bus_rsp_t bus_rsp_r,
    // condition events from the framers and the data-link block
    input wire logic [7:0] fr_event [FIM_NUM_FRAMERS][FIM_NUM_SR],
    input wire logic [7:0] dl_event,
    // performance counters and receive stacks from the framers
    input wire logic [15:0] fr_count [FIM_NUM_FRAMERS][FIM_NUM_CNT],
    input wire logic [7:0] fr_stack [FIM_NUM_FRAMERS][FIM_STACK_LEN],
    // interrupt pin
    output logic irq_out_r,
    output logic irq_oe_r,
    // global control bytes for the rest of the device
    output logic [7:0] global_control_a_r,
    output logic [7:0] global_control_b_r,
    output logic [7:0] synth_clock_control_r
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [3:0] sel;
    logic fr_hit;
    logic [2:0] fr_idx;
    logic [7:0] ofs;
    logic in_sr;
    logic in_cnt;
    logic in_stack;
    logic in_en;
    logic [7:0] cnt_rel;
    logic [7:0] stack_rel;
    logic [4:0] cnt_idx;
    logic [3:0] stack_idx;
    logic [2:0] reg_idx;

    always_comb begin
        sel = fim_framer_sel(bus_req.addr);
        fr_hit = sel[3];
        fr_idx = sel[2:0];
        ofs = bus_req.addr[7:0];
        in_sr = fr_hit && ofs >= FIM_OFS_SR_FIRST && ofs <= FIM_OFS_SR_LAST;
        in_cnt = fr_hit && ofs >= FIM_OFS_CNT_FIRST && ofs <= FIM_OFS_CNT_LAST;
        in_stack = fr_hit && ofs >= FIM_OFS_STACK_FIRST && ofs <= FIM_OFS_STACK_LAST;
        in_en = fr_hit && ofs >= FIM_OFS_EN_FIRST && ofs <= FIM_OFS_EN_LAST;
        cnt_rel = ofs - FIM_OFS_CNT_FIRST;
        stack_rel = ofs - FIM_OFS_STACK_FIRST;
        cnt_idx = cnt_rel[5:1];
        stack_idx = stack_rel[3:0];
        reg_idx = ofs[2:0];
    end

    // ------------------------------------------------------------------
    // interrupt source and enable registers
    // ------------------------------------------------------------------
    logic [7:0] fr_status [FIM_NUM_FRAMERS][FIM_NUM_SR];
    logic [7:0] fr_enable [FIM_NUM_FRAMERS][FIM_NUM_SR];
    logic [FIM_NUM_SR-1:0] fr_pend [FIM_NUM_FRAMERS];
    logic [FIM_NUM_FRAMERS-1:0] fr_pend_any;
    logic [7:0] dl_status;
    logic [7:0] dl_enable;
    logic dl_pend;

    genvar gf;
    genvar gr;
    generate
        for (gf = 0; gf < FIM_NUM_FRAMERS; gf++) begin : g_framer
            for (gr = 0; gr < FIM_NUM_SR; gr++) begin : g_reg
                logic sr_hit;
                logic en_hit;
                assign sr_hit = in_sr && fr_idx == 3'(gf) && reg_idx == 3'(gr);
                assign en_hit = in_en && fr_idx == 3'(gf) && reg_idx == 3'(gr);
                fim_irq_reg u_reg (
                    .sys_clk(sys_clk),
                    .reset(reset),
                    .event_set(fr_event[gf][gr]),
                    .rd_clear(bus_req.rd && sr_hit),
                    .en_wr(bus_req.wr && en_hit),
                    .wdata(bus_req.wdata),
                    .status_r(fr_status[gf][gr]),
                    .enable_r(fr_enable[gf][gr]),
                    .pending(fr_pend[gf][gr])
                );
            end
            assign fr_pend_any[gf] = |fr_pend[gf];
        end
    endgenerate

    // the data-link block has one source register of its own
    fim_irq_reg u_dl_reg (
        .sys_clk(sys_clk),
        .reset(reset),
        .event_set(dl_event),
        .rd_clear(bus_req.rd && bus_req.addr == FIM_ADDR_DL_STATUS),
        .en_wr(bus_req.wr && bus_req.addr == FIM_ADDR_DL_ENABLE),
        .wdata(bus_req.wdata),
        .status_r(dl_status),
        .enable_r(dl_enable),
        .pending(dl_pend)
    );

    // ------------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------------
    logic [7:0] fr_blk_enable_r;
    logic [7:0] dl_blk_enable_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fr_blk_enable_r <= FIM_RST_BYTE;
        end else if (bus_req.wr && bus_req.addr == FIM_ADDR_FR_BLK_ENABLE) begin
            fr_blk_enable_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dl_blk_enable_r <= FIM_RST_BYTE;
        end else if (bus_req.wr && bus_req.addr == FIM_ADDR_DL_BLK_ENABLE) begin
            dl_blk_enable_r <= bus_req.wdata;
        end
    end

    // reset clears the polarity bit, so an asserted interrupt starts high
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            global_control_a_r <= FIM_RST_BYTE;
        end else if (bus_req.wr && bus_req.addr == FIM_ADDR_GLOBAL_CTL_A) begin
            global_control_a_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            global_control_b_r <= FIM_RST_BYTE;
        end else if (bus_req.wr && bus_req.addr == FIM_ADDR_GLOBAL_CTL_B) begin
            global_control_b_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            synth_clock_control_r <= FIM_RST_BYTE;
        end else if (bus_req.wr && bus_req.addr == FIM_ADDR_SYNTH_CLK_CTL) begin
            synth_clock_control_r <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // counter pairing
    // ------------------------------------------------------------------
    // reading the low byte freezes the high byte, so a count that rolls
    // between the two reads cannot tear; the host reads low then high
    logic [7:0] cnt_hold_r;
    logic [15:0] cnt_word;

    assign cnt_word = fr_count[fr_idx][cnt_idx];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_hold_r <= FIM_RST_BYTE;
        end else if (bus_req.rd && in_cnt && !ofs[0]) begin
            cnt_hold_r <= cnt_word[15:8];
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic [7:0] fr_blk_status;
    logic [7:0] dl_blk_status;

    always_comb begin
        fr_blk_status = fr_pend_any;
        dl_blk_status = FIM_RST_BYTE;
        dl_blk_status[FIM_DL_BLK_BIT] = dl_pend;
    end

    always_comb begin
        rdata_nxt = FIM_UNMAPPED_BYTE;
        if (in_sr) begin
            rdata_nxt = fr_status[fr_idx][reg_idx];
        end else if (in_en) begin
            rdata_nxt = fr_enable[fr_idx][reg_idx];
        end else if (in_cnt) begin
            // covers 08-13 and the seconds counters at 14-33
            rdata_nxt = ofs[0] ? cnt_hold_r : cnt_word[7:0];
        end else if (in_stack) begin
            rdata_nxt = fr_stack[fr_idx][stack_idx];
        end else begin
            unique case (bus_req.addr)
                FIM_ADDR_FR_BLK_STATUS: rdata_nxt = fr_blk_status;
                FIM_ADDR_FR_BLK_ENABLE: rdata_nxt = fr_blk_enable_r;
                FIM_ADDR_DL_BLK_STATUS: rdata_nxt = dl_blk_status;
                FIM_ADDR_DL_BLK_ENABLE: rdata_nxt = dl_blk_enable_r;
                FIM_ADDR_GLOBAL_CTL_A: rdata_nxt = global_control_a_r;
                FIM_ADDR_IDENT_0: rdata_nxt = IDENT_0;
                FIM_ADDR_IDENT_1: rdata_nxt = IDENT_1;
                FIM_ADDR_IDENT_2: rdata_nxt = IDENT_2;
                FIM_ADDR_GLOBAL_CTL_B: rdata_nxt = global_control_b_r;
                FIM_ADDR_SYNTH_CLK_CTL: rdata_nxt = synth_clock_control_r;
                FIM_ADDR_DL_STATUS: rdata_nxt = dl_status;
                FIM_ADDR_DL_ENABLE: rdata_nxt = dl_enable;
                default: rdata_nxt = FIM_UNMAPPED_BYTE;
            endcase
        end
    end

    // the answer shows the status as it stood before the clearing edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_rsp_r <= '0;
        end else begin
            bus_rsp_r.valid <= bus_req.rd;
            if (bus_req.rd) begin
                bus_rsp_r.data <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------
    logic [FIM_NUM_FRAMERS-1:0] fr_gated;
    logic irq_any;
    logic irq_polarity;
    logic irq_open_drive;

    always_comb begin
        fr_gated = fr_pend_any & fr_blk_enable_r;
        irq_any = (|fr_gated) || (dl_pend && dl_blk_enable_r[FIM_DL_BLK_BIT]);
        irq_polarity = global_control_a_r[FIM_CTL_POLARITY_BIT];
        irq_open_drive = global_control_a_r[FIM_CTL_OPEN_DRIVE_BIT];
    end

    // pin level and enable are both registered so they switch on the same edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_out_r <= 1'b0;
        end else begin
            irq_out_r <= irq_any ^ irq_polarity;
        end
    end

    // with open drive the idle level is left to the shared pull resistor
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_oe_r <= 1'b1;
        end else begin
            irq_oe_r <= irq_any || !irq_open_drive;
        end
    end

endmodule : fim_top
`default_nettype wire

// ### src/fim_pkg.sv
// package: address map, field positions, reset values and carriers of the framer interrupt block
package fim_pkg;

    // sizes of the device
    localparam int FIM_NUM_FRAMERS = 8;
    localparam int FIM_NUM_SR = 8;
    localparam int FIM_NUM_CNT = 22;
    localparam int FIM_STACK_LEN = 10;

    // global page addresses
    localparam logic [11:0] FIM_ADDR_FR_BLK_STATUS = 12'h000;
    localparam logic [11:0] FIM_ADDR_FR_BLK_ENABLE = 12'h001;
    localparam logic [11:0] FIM_ADDR_DL_BLK_STATUS = 12'h002;
    localparam logic [11:0] FIM_ADDR_DL_BLK_ENABLE = 12'h003;
    localparam logic [11:0] FIM_ADDR_GLOBAL_CTL_A = 12'h004;
    localparam logic [11:0] FIM_ADDR_IDENT_0 = 12'h005;
    localparam logic [11:0] FIM_ADDR_IDENT_1 = 12'h006;
    localparam logic [11:0] FIM_ADDR_IDENT_2 = 12'h007;
    localparam logic [11:0] FIM_ADDR_GLOBAL_CTL_B = 12'h008;
    localparam logic [11:0] FIM_ADDR_SYNTH_CLK_CTL = 12'h009;

    // data-link page
    localparam logic [11:0] FIM_ADDR_DL_STATUS = 12'ha00;
    localparam logic [11:0] FIM_ADDR_DL_ENABLE = 12'ha01;

    // framer page selector digit and offsets within a page
    localparam logic [3:0] FIM_PAGE_FIRST = 4'h2;
    localparam logic [3:0] FIM_PAGE_LAST = 4'h9;
    localparam logic [7:0] FIM_OFS_SR_FIRST = 8'h00;
    localparam logic [7:0] FIM_OFS_SR_LAST = 8'h07;
    localparam logic [7:0] FIM_OFS_CNT_FIRST = 8'h08;
    localparam logic [7:0] FIM_OFS_CNT_LAST = 8'h33;
    localparam logic [7:0] FIM_OFS_STACK_FIRST = 8'h36;
    localparam logic [7:0] FIM_OFS_STACK_LAST = 8'h3f;
    localparam logic [7:0] FIM_OFS_EN_FIRST = 8'h60;
    localparam logic [7:0] FIM_OFS_EN_LAST = 8'h67;

    // field positions
    localparam int FIM_CTL_OPEN_DRIVE_BIT = 4;
    localparam int FIM_CTL_POLARITY_BIT = 6;
    localparam int FIM_DL_BLK_BIT = 0;

    // values after reset and for unmapped reads
    localparam logic [7:0] FIM_RST_BYTE = 8'h00;
    localparam logic [7:0] FIM_UNMAPPED_BYTE = 8'h00;

    // host request and answer carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } fim_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fim_bus_rsp_t;

    // returns {hit, framer index} for an address in a framer page
    function automatic logic [3:0] fim_framer_sel(input logic [11:0] addr);
        logic [3:0] digit;
        logic [3:0] idx;
        digit = addr[11:8];
        idx = digit - FIM_PAGE_FIRST;
        if (digit >= FIM_PAGE_FIRST && digit <= FIM_PAGE_LAST) begin
            fim_framer_sel = {1'b1, idx[2:0]};
        end else begin
            fim_framer_sel = 4'h0;
        end
    endfunction : fim_framer_sel

endpackage : fim_pkg

// ### src/fim_irq_reg.sv
// one interrupt source register with its enable register
`timescale 1ns/1ps
`default_nettype none
module fim_irq_reg
    import fim_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // condition events from the block
    input wire logic [7:0] event_set,
    // host access
    input wire logic rd_clear,
    input wire logic en_wr,
    input wire logic [7:0] wdata,
    // state
    output logic [7:0] status_r,
    output logic [7:0] enable_r,
    output logic pending
);

    // a condition arriving in the clearing cycle stays latched
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_r <= FIM_RST_BYTE;
        end else if (rd_clear) begin
            status_r <= event_set;
        end else begin
            status_r <= status_r | event_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enable_r <= FIM_RST_BYTE;
        end else if (en_wr) begin
            enable_r <= wdata;
        end
    end

    assign pending = |(status_r & enable_r);

endmodule : fim_irq_reg
`default_nettype wire

// ### tb/fim_top_chk.sv
// assertion checker for the interrupt pin and the host read answer
`timescale 1ns/1ps
`default_nettype none
module fim_top_chk
    import fim_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // host port
    input wire fim_bus_req_t bus_req,
    input wire fim_bus_rsp_t bus_rsp_r,
    // sources and pin
    input wire logic [7:0] dl_event,
    input wire logic irq_out_r,
    input wire logic irq_oe_r,
    input wire logic [7:0] global_control_a_r
);
    logic [7:0] fen_r;
    logic [7:0] den_r;
    logic [7:0] dle_r;
    logic pol_r;
    logic od_r;
    logic on_w;
    // enables mirrored from write traffic, since the checker cannot see inside
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fen_r <= 8'h00;
            den_r <= 8'h00;
            dle_r <= 8'h00;
        end else if (bus_req.wr) begin
            if (bus_req.addr == FIM_ADDR_FR_BLK_ENABLE) fen_r <= bus_req.wdata;
            if (bus_req.addr == FIM_ADDR_DL_BLK_ENABLE) den_r <= bus_req.wdata;
            if (bus_req.addr == FIM_ADDR_DL_ENABLE) dle_r <= bus_req.wdata;
        end
    end
    // the pin follows the control byte one edge late
    always_ff @(posedge sys_clk) begin
        pol_r <= global_control_a_r[FIM_CTL_POLARITY_BIT];
        od_r <= global_control_a_r[FIM_CTL_OPEN_DRIVE_BIT];
    end
    assign on_w = irq_oe_r && (irq_out_r != pol_r);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_quiet;
        !bus_req.rd && !bus_req.wr && dl_event == 8'h00;
    endsequence
    sequence s_dl_hit;
        (dl_event & dle_r) != 8'h00 && den_r[FIM_DL_BLK_BIT] && !bus_req.wr;
    endsequence
    sequence s_dl_read;
        bus_req.rd && bus_req.addr == FIM_ADDR_DL_STATUS && fen_r == 8'h00 && dl_event == 8'h00;
    endsequence
    rd_answer_a: assert property (bus_req.rd |=> bus_rsp_r.valid)
        else $error("read not answered");
    rd_single_a: assert property (!bus_req.rd |=> !bus_rsp_r.valid)
        else $error("answer without read");
    idle_float_a: assert property (!irq_oe_r |-> od_r && irq_out_r == pol_r)
        else $error("pin floated wrongly");
    push_pull_a: assert property (!od_r |-> irq_oe_r)
        else $error("pin not driven");
    float_level_a: assert property (od_r && irq_oe_r |-> irq_out_r != pol_r)
        else $error("driven level wrong");
    reset_level_a: assert property ($fell(reset) |-> irq_oe_r && !irq_out_r)
        else $error("pin wrong after reset");
    blk_gate_a: assert property (fen_r == 8'h00 && !den_r[FIM_DL_BLK_BIT] |=> !on_w)
        else $error("irq with blocks disabled");
    dl_raise_a: assert property (s_dl_hit ##1 s_quiet |=> on_w)
        else $error("enabled event no irq");
    rd_clear_a: assert property (s_dl_read ##1 s_quiet |=> !on_w)
        else $error("irq kept after read");
endmodule : fim_top_chk
`default_nettype wire

// ### tb/fim_host.sv
// host model: one register read or write at a time, driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module fim_host
    import fim_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // register port
    output var fim_bus_req_t bus_req,
    input wire fim_bus_rsp_t bus_rsp_r
);
    initial bus_req = '0;
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        bus_req.wr = 1'b1;
        bus_req.addr = a;
        bus_req.wdata = d;
        @(negedge sys_clk);
        bus_req.wr = 1'b0;
        // released lines show the inverse so stale values never look valid
        bus_req.addr = ~a;
        bus_req.wdata = ~d;
    endtask : wr_reg
    // a status read clears what it returns, so the caller keeps the value
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(negedge sys_clk);
        bus_req.rd = 1'b1;
        bus_req.addr = a;
        @(negedge sys_clk);
        bus_req.rd = 1'b0;
        bus_req.addr = ~a;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 4 && !ok; n++) begin
            if (bus_rsp_r.valid === 1'b1) begin
                ok = 1'b1;
                d = bus_rsp_r.data;
            end else @(negedge sys_clk);
        end
    endtask : rd_reg
endmodule : fim_host
`default_nettype wire

// ### tb/fim_top_tb_top.sv
// self-checking bench for the framer interrupt block
`timescale 1ns/1ps
`default_nettype none
module fim_top_tb_top
    import fim_pkg::*;
;
    typedef struct packed { logic wr; logic [11:0] a; logic [7:0] d; } fim_row_t;
    // identification bytes; the values are arbitrary
    localparam logic [7:0] ID0 = 8'h3c;
    localparam logic [7:0] ID1 = 8'h7e;
    localparam logic [7:0] ID2 = 8'h81;
    logic sys_clk;
    logic reset;
    fim_bus_req_t bus_req;
    fim_bus_rsp_t bus_rsp_r;
    logic [7:0] fr_event [FIM_NUM_FRAMERS][FIM_NUM_SR];
    logic [7:0] dl_event;
    logic [15:0] fr_count [FIM_NUM_FRAMERS][FIM_NUM_CNT];
    logic [7:0] fr_stack [FIM_NUM_FRAMERS][FIM_STACK_LEN];
    logic irq_out_r;
    logic irq_oe_r;
    logic [7:0] gca;
    logic [7:0] gc;
    logic [7:0] gcb;
    logic [7:0] scc;
    int n_errors;
    int n_compared;
    int i;
    fim_row_t rows [$] = '{'{1, 12'h001, 8'ha5}, '{0, 12'h001, 8'ha5}, '{1, 12'h003, 8'h5a},
        '{0, 12'h003, 8'h5a}, '{0, 12'h005, ID0}, '{0, 12'h006, ID1}, '{0, 12'h007, ID2},
        '{1, 12'h005, 8'h00}, '{0, 12'h005, ID0}, '{1, 12'h000, 8'hff}, '{0, 12'h000, 8'h00},
        '{0, 12'h208, 8'h40}, '{0, 12'h209, 8'h80}, '{0, 12'h20a, 8'h41}, '{0, 12'h20b, 8'h81},
        '{0, 12'h20c, 8'h42}, '{0, 12'h20d, 8'h82}, '{0, 12'h20e, 8'h43}, '{0, 12'h20f, 8'h83},
        '{0, 12'h214, 8'h46}, '{0, 12'h215, 8'h86}, '{0, 12'h232, 8'h55}, '{0, 12'h233, 8'h95},
        '{0, 12'h908, 8'h40}, '{0, 12'h909, 8'h60}, '{0, 12'h236, 8'h0f}, '{0, 12'h23f, 8'h06},
        '{0, 12'h936, 8'h7f}, '{1, 12'h260, 8'h3c}, '{0, 12'h260, 8'h3c}, '{1, 12'h967, 8'hc3},
        '{0, 12'h967, 8'hc3}, '{0, 12'h034, 8'h00}, '{0, 12'hb00, 8'h00}, '{1, 12'h008, 8'h96},
        '{0, 12'h008, 8'h96}, '{1, 12'h009, 8'h69}, '{0, 12'h009, 8'h69}, '{1, 12'h001, 8'h00},
        '{1, 12'h003, 8'h00}};
    fim_host u_fim_host (.sys_clk(sys_clk), .bus_req(bus_req), .bus_rsp_r(bus_rsp_r));
    fim_top #(.IDENT_0(ID0), .IDENT_1(ID1), .IDENT_2(ID2)) u_fim_top (.sys_clk(sys_clk), .reset(reset),
        .bus_req(bus_req), .bus_rsp_r(bus_rsp_r), .fr_event(fr_event), .dl_event(dl_event),
        .fr_count(fr_count), .fr_stack(fr_stack), .irq_out_r(irq_out_r), .irq_oe_r(irq_oe_r),
        .global_control_a_r(gca), .global_control_b_r(gcb), .synth_clock_control_r(scc));
    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_fim_host.rd_reg(a, d, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
        chk(d, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_fim_host.wr_reg(a, d);
        if (a == FIM_ADDR_GLOBAL_CTL_A) gc = d;
    endtask : wr
    // pin pair {oe, out} after the two-edge latency has settled
    task automatic pin(input logic on);
        repeat (2) @(negedge sys_clk);
        chk({6'h00, irq_oe_r, irq_out_r}, on ? {7'h01, ~gc[6]} : {6'h00, ~gc[4], gc[6]});
    endtask : pin
    task automatic dl_pulse(input logic [7:0] v);
        @(negedge sys_clk);
        dl_event = v;
        @(negedge sys_clk);
        dl_event = 8'h00;
    endtask : dl_pulse
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1'b1;
        dl_event = 8'h00;
        gc = 8'h00;
        n_errors = 0;
        n_compared = 0;
        for (int f = 0; f < FIM_NUM_FRAMERS; f++) begin
            for (int k = 0; k < FIM_NUM_SR; k++) fr_event[f][k] = 8'h00;
            for (int k = 0; k < FIM_NUM_CNT; k++) fr_count[f][k] = {{3'(f), 5'(k)} ^ 8'h80, 8'(k) + 8'h40};
            for (int k = 0; k < FIM_STACK_LEN; k++) fr_stack[f][k] = {4'(f), 4'(k)} ^ 8'h0f;
        end
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        pin(1'b0);
        rd(FIM_ADDR_GLOBAL_CTL_A, 8'h00);
        foreach (rows[r]) begin
            if (rows[r].wr) wr(rows[r].a, rows[r].d);
            else rd(rows[r].a, rows[r].d);
        end
        chk(gcb, 8'h96);
        chk(scc, 8'h69);
        wr(FIM_ADDR_DL_ENABLE, 8'h01);
        dl_pulse(8'h01);
        pin(1'b0);
        rd(FIM_ADDR_DL_BLK_STATUS, 8'h01);
        wr(FIM_ADDR_DL_BLK_ENABLE, 8'h01);
        pin(1'b1);
        rd(FIM_ADDR_DL_STATUS, 8'h01);
        pin(1'b0);
        dl_pulse(8'h02);
        pin(1'b0);
        rd(FIM_ADDR_DL_STATUS, 8'h02);
        wr(12'h565, 8'h04);
        @(negedge sys_clk);
        fr_event[3][5] = 8'h04;
        @(negedge sys_clk);
        fr_event[3][5] = 8'h00;
        pin(1'b0);
        wr(FIM_ADDR_FR_BLK_ENABLE, 8'h08);
        pin(1'b1);
        rd(FIM_ADDR_FR_BLK_STATUS, 8'h08);
        rd(12'h505, 8'h04);
        pin(1'b0);
        for (i = 0; i < 4; i++) begin
            wr(FIM_ADDR_GLOBAL_CTL_A, {1'b0, i[1], 1'b0, i[0], 4'h0});
            chk(gca, gc);
            pin(1'b0);
            dl_pulse(8'h01);
            pin(1'b1);
            rd(FIM_ADDR_DL_STATUS, 8'h01);
            pin(1'b0);
        end
        give_verdict();
    end
endmodule : fim_top_tb_top
bind fim_top fim_top_chk u_fim_top_chk (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
    .bus_rsp_r(bus_rsp_r), .dl_event(dl_event), .irq_out_r(irq_out_r), .irq_oe_r(irq_oe_r),
    .global_control_a_r(global_control_a_r));
`default_nettype wire
